/* File: pkg/cpn_pkg.sv */
// Negotiation block constants and types
`default_nettype none
package cpn_pkg;
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
  localparam int unsigned CYC_PER_US = CLK_HZ / 1_000_000;

  // Times as specified, in their own units
  localparam int unsigned T_PD_WAIT_MS = 7500;
  localparam int unsigned T_HRST_OFF_MS = 850;
  localparam int unsigned T_DEGLITCH_MS = 40;
  localparam int unsigned T_DISCH_MS = 200;
  localparam int unsigned T_VCONN_MS = 60;
  localparam int unsigned T_SWLOSS_MS = 40;
  localparam int unsigned T_CBL_WAIT_MS = 30;
  localparam int unsigned T_CAPS_MS = 150;
  localparam int unsigned T_OPTO_BIT_US = 100;

  localparam int unsigned PD_WAIT_CYC = T_PD_WAIT_MS * CYC_PER_MS;
  localparam int unsigned HRST_CYC = T_HRST_OFF_MS * CYC_PER_MS;
  localparam int unsigned DEGL_CYC = T_DEGLITCH_MS * CYC_PER_MS;
  localparam int unsigned DISCH_CYC = T_DISCH_MS * CYC_PER_MS;
  localparam int unsigned VCONN_CYC = T_VCONN_MS * CYC_PER_MS;
  localparam int unsigned SWLOSS_CYC = T_SWLOSS_MS * CYC_PER_MS;
  localparam int unsigned CBL_WAIT_CYC = T_CBL_WAIT_MS * CYC_PER_MS;
  localparam int unsigned CAPS_CYC = T_CAPS_MS * CYC_PER_MS;
  localparam int unsigned OPTO_BIT_CYC = T_OPTO_BIT_US * CYC_PER_US;

  // Voltage in 20 mV units, current in 50 mA units
  localparam logic [11:0] V5_CODE = 12'h0FA;
  localparam logic [11:0] V9_CODE = 12'h1C2;
  localparam logic [11:0] V12_CODE = 12'h258;
  localparam logic [6:0] CUR_3A = 7'h3C;
  localparam logic [6:0] CUR_MAX_DEF = 7'h64;
  localparam logic [6:0] CUR_DEF = 7'h3C;
  localparam int unsigned NUM_PDO_DEF = 7;
  localparam int unsigned OPTO_BITS = 20;

  // Line classes {high, low} comparator
  typedef enum logic [1:0] {
    LINE_0V0 = 2'h0,
    LINE_0V6 = 2'h1,
    LINE_3V3 = 2'h3
  } cpn_line_t;

  typedef enum logic [2:0] {
    RX_REQUEST  = 3'h1,
    RX_HARD_RST = 3'h2,
    RX_PPS_STAT = 3'h3,
    RX_STATUS   = 3'h4,
    RX_CABLE_ID = 3'h5
  } cpn_rx_kind_t;

  typedef enum logic [2:0] {
    TX_SRC_CAPS = 3'h1,
    TX_ACCEPT   = 3'h2,
    TX_REJECT   = 3'h3,
    TX_PS_RDY   = 3'h4,
    TX_DISC_ID  = 3'h5,
    TX_PPS_STAT = 3'h6,
    TX_STATUS   = 3'h7
  } cpn_tx_kind_t;

  typedef struct packed {
    logic         valid;
    cpn_rx_kind_t kind;
    logic         rev3;
    logic [2:0]   obj;
    logic [11:0]  volt;
    logic [6:0]   curr;
  } cpn_rx_t;

  typedef struct packed {
    logic         valid;
    cpn_tx_kind_t kind;
    logic         rev3;
    logic         to_cable;
    logic [2:0]   num_pdo;
    logic         cap_3a;
    logic [27:0]  payload;
  } cpn_tx_t;

  typedef struct packed {
    logic        valid;
    logic [11:0] vbus;
    logic [7:0]  ibus;
    logic [7:0]  temp;
  } cpn_meas_t;

  typedef struct packed {
    logic pd_mode;
    logic legacy_mode;
    logic caps_on;
    logic cap_3a;
    logic rev3;
  } cpn_stat_t;
endpackage
`default_nettype wire

/* File: core/cpn_core.sv */
// Charger protocol negotiation core
`default_nettype none
// Notes on behaviour
// - Attach closes switch, 5V, send capabilities
// - Detect charging port, then legacy protocol
// - Legacy mode early; capabilities keep going
// - PD timeout stops capabilities, mode stays
// - Explicit contract: leave legacy, stay PD
// - Hard reset: switch off, reclose, redetect
// - Use revision 3.0, fall back 2.0
// - Advertise up to seven supply objects
// - Valid request sent as opto pulses
// - Tell sink when output reaches target
// - Programmable supply: 20mV, 50mA steps
// - Store measurements, answer status requests
// - Switching loss opens switch, drops source
// - Switching loss timeout is 40 ms
// - Cable enabled: power spare CC at 5V
// - After 60ms, ask cable identity
// - Cable off; no reply caps at 3A
// - Cable read after plug-in, hard reset
// - Legacy entry needs 40ms stable change
// - Classify lines 0V, 0.6V, 3.3V
// - Line pairs select 12V/9V/continuous/5V
// - Fast discharge start/stop, 200ms limit
// - Slow discharge until 200ms timer ends
// - Detach restores switch, setpoint and mode defaults
module cpn_core #(
  parameter int unsigned PD_WAIT_CYC  = cpn_pkg::PD_WAIT_CYC,
  parameter int unsigned HRST_CYC     = cpn_pkg::HRST_CYC,
  parameter int unsigned DEGL_CYC     = cpn_pkg::DEGL_CYC,
  parameter int unsigned DISCH_CYC    = cpn_pkg::DISCH_CYC,
  parameter int unsigned VCONN_CYC    = cpn_pkg::VCONN_CYC,
  parameter int unsigned SWLOSS_CYC   = cpn_pkg::SWLOSS_CYC,
  parameter int unsigned CBL_WAIT_CYC = cpn_pkg::CBL_WAIT_CYC,
  parameter int unsigned CAPS_CYC     = cpn_pkg::CAPS_CYC,
  parameter int unsigned OPTO_BIT_CYC = cpn_pkg::OPTO_BIT_CYC,
  parameter int unsigned NUM_PDO      = cpn_pkg::NUM_PDO_DEF,
  parameter logic [6:0]  CUR_MAX      = cpn_pkg::CUR_MAX_DEF
) (
  input  wire logic               sys_clk_i,
  input  wire logic               rst_b_i,
  input  wire logic               attach_i,
  input  wire logic               rd_on_cc2_i,
  input  wire logic               vbus_at_5v_i,
  input  wire logic               vbus_at_target_i,
  input  wire logic               disch_thresh_i,
  input  wire logic               cable_read_en_i,
  input  wire logic               switching_detect_input_i,
  input  wire logic [1:0]         dp_level_i,
  input  wire logic [1:0]         dm_level_i,
  input  wire cpn_pkg::cpn_rx_t   pd_rx_i,
  input  wire cpn_pkg::cpn_meas_t meas_i,
  output var  cpn_pkg::cpn_tx_t   pd_tx_o,
  output var  cpn_pkg::cpn_stat_t stat_o,
  output logic                    bus_switch_o,
  output logic [1:0]              cc_source_o,
  output logic [1:0]              vconn_o,
  output logic                    opto_drive_output_o,
  output logic                    disch_fast_o,
  output logic                    disch_slow_o,
  output logic [11:0]             volt_set_o,
  output logic [6:0]              curr_set_o,
  output logic                    cont_mode_o
);
  typedef enum logic [6:0] {
    ST_IDLE  = 7'h01,
    ST_PWRUP = 7'h02,
    ST_CABLE = 7'h04,
    ST_NEG   = 7'h08,
    ST_PD    = 7'h10,
    ST_HRST  = 7'h20,
    ST_LOCK  = 7'h40
  } cpn_state_t;

  logic rst_meta, rst_n;
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  cpn_state_t state, next_state;
  logic [27:0] tmr, pdw;
  logic [21:0] caps_cnt;
  logic [19:0] swl_cnt, degl_cnt;
  logic [22:0] dis_cnt;
  logic [11:0] opto_cnt;
  logic [4:0]  opto_bits;
  logic [19:0] opto_sh;
  logic [3:0]  combo_last, combo_acc;
  logic        sw_prev, caps_on, rev3, cap_3a, bc_done, legacy, cbl_sent;
  logic        ps_rdy_pend, dis_on, dis_fast;
  logic [11:0] volt;
  logic [6:0]  curr;
  logic        cont;
  logic [27:0] meas_st;

  // Message decode
  wire rx_req   = pd_rx_i.valid && pd_rx_i.kind == cpn_pkg::RX_REQUEST;
  wire rx_hrst  = pd_rx_i.valid && pd_rx_i.kind == cpn_pkg::RX_HARD_RST;
  wire rx_pps   = pd_rx_i.valid && pd_rx_i.kind == cpn_pkg::RX_PPS_STAT;
  wire rx_stat  = pd_rx_i.valid && pd_rx_i.kind == cpn_pkg::RX_STATUS;
  wire rx_cable = pd_rx_i.valid && pd_rx_i.kind == cpn_pkg::RX_CABLE_ID && state == ST_CABLE && cbl_sent;
  wire in_neg   = state == ST_NEG;
  wire in_pd    = state == ST_PD;
  wire live     = in_neg || in_pd;

  wire [6:0] cur_lim = cap_3a ? cpn_pkg::CUR_3A : CUR_MAX;
  wire req_ok = pd_rx_i.obj != 3'h0 && 32'(pd_rx_i.obj) <= NUM_PDO && pd_rx_i.curr <= cur_lim;
  wire req_take = rx_req && live && req_ok;

  // Timers
  wire vconn_done = tmr == 28'(VCONN_CYC - 1);
  wire cbl_tmo    = tmr == 28'(VCONN_CYC + CBL_WAIT_CYC - 1);
  wire hrst_done  = tmr == 28'(HRST_CYC - 1);
  wire pd_tmo     = caps_on && pdw == 28'(PD_WAIT_CYC - 1);
  wire caps_due   = caps_on && in_neg && caps_cnt == 22'h000000;
  wire sw_edge    = switching_detect_input_i != sw_prev;
  wire sw_lost    = live && swl_cnt == 20'(SWLOSS_CYC - 1);

  wire [1:0] dp_cls = dp_level_i[1] ? cpn_pkg::LINE_3V3 : (dp_level_i[0] ? cpn_pkg::LINE_0V6 : cpn_pkg::LINE_0V0);
  wire [1:0] dm_cls = dm_level_i[1] ? cpn_pkg::LINE_3V3 : (dm_level_i[0] ? cpn_pkg::LINE_0V6 : cpn_pkg::LINE_0V0);
  wire [3:0] combo  = {dp_cls, dm_cls};
  wire combo_ev = combo == combo_last && combo != combo_acc && degl_cnt == 20'(DEGL_CYC - 1);

  wire is_12 = combo == {cpn_pkg::LINE_0V6, cpn_pkg::LINE_0V6};
  wire is_9  = combo == {cpn_pkg::LINE_3V3, cpn_pkg::LINE_0V6};
  wire is_ct = combo == {cpn_pkg::LINE_0V6, cpn_pkg::LINE_3V3};
  wire is_5  = combo == {cpn_pkg::LINE_0V6, cpn_pkg::LINE_0V0};
  wire dp_drop = combo[3:2] == cpn_pkg::LINE_0V0;
  wire [11:0] leg_v = is_12 ? cpn_pkg::V12_CODE : (is_9 ? cpn_pkg::V9_CODE : cpn_pkg::V5_CODE);
  // port detection first, then legacy handshake
  wire bc_ev    = combo_ev && in_neg && !bc_done && dp_cls == cpn_pkg::LINE_0V6;
  wire leg_ev   = combo_ev && in_neg && bc_done && !legacy && is_5;
  wire leg_req  = combo_ev && in_neg && legacy && (is_12 || is_9 || is_5);
  wire leg_cont = combo_ev && in_neg && legacy && is_ct;
  wire drop_ev  = combo_ev && in_neg && legacy && dp_drop && volt > cpn_pkg::V5_CODE;

  // New setpoint from either protocol
  wire        set_chg  = req_take || (leg_req && leg_v != volt) || drop_ev;
  wire [11:0] set_v    = req_take ? pd_rx_i.volt : (drop_ev ? cpn_pkg::V5_CODE : leg_v);
  wire [6:0]  set_c    = req_take ? pd_rx_i.curr : cpn_pkg::CUR_DEF;
  wire        lower    = set_chg && set_v < volt;
  wire        opto_busy = opto_bits != 5'h00;

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE:  if (attach_i) next_state = ST_PWRUP;
      // wait for the 5V output before talking
      ST_PWRUP: if (vbus_at_5v_i) next_state = cable_read_en_i ? ST_CABLE : ST_NEG;
      // leave cable read on reply or timeout
      ST_CABLE: if (rx_cable || cbl_tmo) next_state = ST_NEG;
      ST_NEG:   if (req_take) next_state = ST_PD;
      ST_PD:    next_state = ST_PD;
      ST_HRST:  if (hrst_done) next_state = ST_PWRUP;
      ST_LOCK:  next_state = ST_LOCK;
      default:  next_state = ST_IDLE;
    endcase
    // hard reset restarts detection and cable read
    if (live && rx_hrst) next_state = ST_HRST;
    if (sw_lost) next_state = ST_LOCK;
    if (!attach_i) next_state = ST_IDLE;
  end

  wire enter_neg = next_state == ST_NEG && state != ST_NEG;
  wire tmr_clr   = next_state != state;

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      tmr <= 28'h0000000;
    end else begin
      state <= next_state;
      tmr <= tmr_clr ? 28'h0000000 : tmr + 28'h0000001;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      caps_on <= 1'b0;
      pdw <= 28'h0000000;
      caps_cnt <= 22'h000000;
    end else if (enter_neg || !in_neg || pd_tmo) begin
      caps_on <= enter_neg;
      pdw <= 28'h0000000;
      caps_cnt <= 22'h000000;
    end else if (caps_on) begin
      pdw <= pdw + 28'h0000001;
      caps_cnt <= caps_cnt == 22'(CAPS_CYC - 1) ? 22'h000000 : caps_cnt + 22'h000001;
    end
  end

  // Line deglitch and legacy detection flags
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      combo_last <= 4'h0;
      combo_acc <= 4'h0;
      degl_cnt <= 20'h00000;
    end else begin
      combo_last <= combo;
      degl_cnt <= (combo != combo_last || combo_ev) ? 20'h00000 :
                  (degl_cnt == 20'(DEGL_CYC - 1) ? degl_cnt : degl_cnt + 20'h00001);
      if (combo_ev) combo_acc <= combo;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      bc_done <= 1'b0;
      legacy <= 1'b0;
      cont <= 1'b0;
    end else if (enter_neg || !in_neg) begin
      bc_done <= 1'b0;
      legacy <= 1'b0;
      cont <= 1'b0;
    end else begin
      if (bc_ev) bc_done <= 1'b1;
      if (leg_ev) legacy <= 1'b1;
      if (req_take) legacy <= 1'b0;
      if (leg_cont) cont <= 1'b1;
      else if (leg_req) cont <= 1'b0;
    end
  end

  // 20 mV and 50 mA units
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      volt <= cpn_pkg::V5_CODE;
      curr <= cpn_pkg::CUR_DEF;
    end else if (!live) begin
      volt <= cpn_pkg::V5_CODE;
      curr <= cpn_pkg::CUR_DEF;
    end else if (set_chg) begin
      volt <= set_v;
      curr <= set_c;
    end
  end

  // follow the sink revision; cable cap
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rev3 <= 1'b1;
      cap_3a <= 1'b1;
      cbl_sent <= 1'b0;
    end else if (state == ST_IDLE || state == ST_HRST) begin
      rev3 <= 1'b1;
      cap_3a <= 1'b1;
      cbl_sent <= 1'b0;
    end else begin
      if (pd_rx_i.valid && state != ST_CABLE) rev3 <= pd_rx_i.rev3;
      if (state == ST_CABLE && vconn_done) cbl_sent <= 1'b1;
      if (rx_cable) cap_3a <= pd_rx_i.curr <= cpn_pkg::CUR_3A;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) meas_st <= 28'h0000000;
    else if (meas_i.valid) meas_st <= {meas_i.vbus, meas_i.ibus, meas_i.temp};
  end

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      sw_prev <= 1'b0;
      swl_cnt <= 20'h00000;
    end else begin
      sw_prev <= switching_detect_input_i;
      swl_cnt <= (sw_edge || !live) ? 20'h00000 : (sw_lost ? swl_cnt : swl_cnt + 20'h00001);
    end
  end

  // setpoint shifted out as a start bit, voltage, current
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      opto_sh <= 20'h00000;
      opto_bits <= 5'h00;
      opto_cnt <= 12'h000;
    end else if (set_chg) begin
      opto_sh <= {1'b1, set_v, set_c};
      opto_bits <= 5'(cpn_pkg::OPTO_BITS);
      opto_cnt <= 12'h000;
    end else if (opto_busy) begin
      if (opto_cnt == 12'(OPTO_BIT_CYC - 1)) begin
        opto_cnt <= 12'h000;
        opto_sh <= {opto_sh[18:0], 1'b0};
        opto_bits <= opto_bits - 5'h01;
      end else begin
        opto_cnt <= opto_cnt + 12'h001;
      end
    end
  end

  // discharge window shared by fast and slow paths
  wire dis_end = dis_on && dis_cnt == 23'(DISCH_CYC - 1);
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      dis_on <= 1'b0;
      dis_fast <= 1'b0;
      dis_cnt <= 23'h000000;
    end else if (lower) begin
      dis_on <= 1'b1;
      dis_fast <= 1'b1;
      // Deglitch time already counts toward the window
      dis_cnt <= drop_ev ? 23'(DEGL_CYC) : 23'h000000;
    end else if (dis_on) begin
      dis_cnt <= dis_cnt + 23'h000001;
      if (dis_end) dis_on <= 1'b0;
      if (dis_end || disch_thresh_i) dis_fast <= 1'b0;
    end
  end

  // ready once opto done and output arrived
  wire ps_rdy_go = ps_rdy_pend && !opto_busy && !set_chg && vbus_at_target_i;
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) ps_rdy_pend <= 1'b0;
    else if (!live) ps_rdy_pend <= 1'b0;
    else if (req_take) ps_rdy_pend <= 1'b1;
    else if (ps_rdy_go) ps_rdy_pend <= 1'b0;
  end

  // Transmit selection, one message a cycle
  wire send_disc = state == ST_CABLE && vconn_done;
  wire send_resp = rx_req && live;
  wire send_stat = (rx_pps || rx_stat) && live;
  wire tx_any    = send_disc || send_resp || send_stat || ps_rdy_go || caps_due;
  cpn_pkg::cpn_tx_kind_t tx_kind;
  assign tx_kind = send_disc ? cpn_pkg::TX_DISC_ID :
                   send_resp ? (req_ok ? cpn_pkg::TX_ACCEPT : cpn_pkg::TX_REJECT) :
                   send_stat ? (rx_pps ? cpn_pkg::TX_PPS_STAT : cpn_pkg::TX_STATUS) :
                   ps_rdy_go ? cpn_pkg::TX_PS_RDY : cpn_pkg::TX_SRC_CAPS;

  // Output drive decoded from the next state
  wire sw_closed = next_state == ST_PWRUP || next_state == ST_CABLE || next_state == ST_NEG || next_state == ST_PD;
  wire [1:0] rd_pin = rd_on_cc2_i ? 2'h2 : 2'h1;
  wire vconn_on = next_state == ST_CABLE && !(state == ST_CABLE && (rx_cable || cbl_tmo));

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pd_tx_o <= '0;
      stat_o <= '0;
      bus_switch_o <= 1'b0;
      cc_source_o <= 2'h0;
      vconn_o <= 2'h0;
    end else begin
      pd_tx_o.valid <= tx_any;
      pd_tx_o.kind <= tx_kind;
      pd_tx_o.rev3 <= rev3;
      pd_tx_o.to_cable <= send_disc;
      pd_tx_o.num_pdo <= 3'(NUM_PDO);
      pd_tx_o.cap_3a <= cap_3a;
      pd_tx_o.payload <= send_stat ? meas_st : {volt, 9'h000, curr};
      stat_o <= '{pd_mode: next_state == ST_PD, legacy_mode: legacy, caps_on: caps_on,
                  cap_3a: cap_3a, rev3: rev3};
      // switch and CC source follow the state
      bus_switch_o <= sw_closed;
      cc_source_o <= sw_closed ? rd_pin : 2'h0;
      // power the spare CC pin during cable read
      vconn_o <= vconn_on ? ~rd_pin : 2'h0;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      opto_drive_output_o <= 1'b0;
      disch_fast_o <= 1'b0;
      disch_slow_o <= 1'b0;
      volt_set_o <= cpn_pkg::V5_CODE;
      curr_set_o <= cpn_pkg::CUR_DEF;
      cont_mode_o <= 1'b0;
    end else begin
      opto_drive_output_o <= opto_busy && opto_sh[19];
      disch_fast_o <= dis_fast;
      disch_slow_o <= dis_on && !dis_fast;
      volt_set_o <= volt;
      curr_set_o <= curr;
      cont_mode_o <= cont;
    end
  end
endmodule
`default_nettype wire

/* File: tb/cpn_core_assertions.sv */
// Port checks for the negotiation core
`default_nettype none
module cpn_core_checker #(
  parameter int unsigned DISCH_CYC  = 100,
  parameter int unsigned SWLOSS_CYC = 40
) (
  input wire logic               sys_clk_i,
  input wire logic               rst_b_i,
  input wire logic               attach_i,
  input wire logic               rd_on_cc2_i,
  input wire logic               vbus_at_target_i,
  input wire logic               switching_detect_input_i,
  input wire cpn_pkg::cpn_rx_t   pd_rx_i,
  input wire cpn_pkg::cpn_tx_t   pd_tx_o,
  input wire cpn_pkg::cpn_stat_t stat_o,
  input wire logic               bus_switch_o,
  input wire logic [1:0]         cc_source_o,
  input wire logic [1:0]         vconn_o,
  input wire logic               opto_drive_output_o,
  input wire logic               disch_fast_o,
  input wire logic               disch_slow_o,
  input wire logic [11:0]        volt_set_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);
  int unsigned dcnt, scnt;
  logic        sw_q;
  // Run lengths
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      dcnt <= 0;
      scnt <= 0;
      sw_q <= 1'b0;
    end else begin
      dcnt <= (disch_fast_o || disch_slow_o) ? dcnt + 1 : 0;
      scnt <= (sw_q != switching_detect_input_i) ? 0 : scnt + 1;
      sw_q <= switching_detect_input_i;
    end
  end
  sequence s_hrst;
    pd_rx_i.valid && pd_rx_i.kind == cpn_pkg::RX_HARD_RST && (stat_o.pd_mode || stat_o.legacy_mode);
  endsequence
  sequence s_off;
    !bus_switch_o [*8];
  endsequence
  sequence s_req;
    pd_rx_i.valid && pd_rx_i.kind == cpn_pkg::RX_REQUEST && stat_o.pd_mode;
  endsequence
  pin_select_a: assert property (
    cc_source_o != 2'h0 |-> bus_switch_o && cc_source_o == (rd_on_cc2_i ? 2'h2 : 2'h1))
    else $error("cc source pin");
  cable_pin_a: assert property (vconn_o != 2'h0 |-> vconn_o == (rd_on_cc2_i ? 2'h1 : 2'h2))
    else $error("cable pin");
  hard_rst_off_a: assert property (s_hrst |-> ##[1:3] s_off)
    else $error("hard reset switch");
  req_accept_a: assert property (
    s_req ##0 (pd_rx_i.obj != 3'h0 && pd_rx_i.curr <= cpn_pkg::CUR_3A) |=> pd_tx_o.valid && pd_tx_o.kind == cpn_pkg::TX_ACCEPT)
    else $error("no accept");
  obj_reject_a: assert property (s_req ##0 pd_rx_i.obj == 3'h0 |=> pd_tx_o.kind == cpn_pkg::TX_REJECT)
    else $error("no reject");
  opto_start_a: assert property (
    pd_tx_o.valid && pd_tx_o.kind == cpn_pkg::TX_ACCEPT |-> ##[0:8] opto_drive_output_o)
    else $error("no opto frame");
  ready_cause_a: assert property (pd_tx_o.valid && pd_tx_o.kind == cpn_pkg::TX_PS_RDY |-> $past(vbus_at_target_i))
    else $error("early ready");
  disch_excl_a: assert property (!(disch_fast_o && disch_slow_o))
    else $error("both discharges");
  disch_len_a: assert property (dcnt <= DISCH_CYC)
    else $error("discharge too long");
  sw_loss_a: assert property (stat_o.pd_mode && scnt > SWLOSS_CYC + 4 |-> !bus_switch_o)
    else $error("switch after loss");
  detach_dflt_a: assert property (
    !attach_i [*3] |=> !bus_switch_o && cc_source_o == 2'h0 && !stat_o.pd_mode && volt_set_o == cpn_pkg::V5_CODE)
    else $error("detach defaults");
endmodule
bind cpn_core cpn_core_checker #(.DISCH_CYC(DISCH_CYC), .SWLOSS_CYC(SWLOSS_CYC)) u_cpn_core_checker (
  .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .attach_i(attach_i), .rd_on_cc2_i(rd_on_cc2_i),
  .vbus_at_target_i(vbus_at_target_i), .switching_detect_input_i(switching_detect_input_i),
  .pd_rx_i(pd_rx_i), .pd_tx_o(pd_tx_o), .stat_o(stat_o), .bus_switch_o(bus_switch_o),
  .cc_source_o(cc_source_o), .vconn_o(vconn_o), .opto_drive_output_o(opto_drive_output_o),
  .disch_fast_o(disch_fast_o), .disch_slow_o(disch_slow_o), .volt_set_o(volt_set_o));
`default_nettype wire

/* File: tb/cpn_sink_model.sv */
// Sink and marked cable model
`default_nettype none
module cpn_sink_model (
  input  wire logic             sys_clk_i,
  input  wire cpn_pkg::cpn_tx_t pd_tx_i,
  input  wire logic [6:0]       cable_rating_i,
  input  wire logic [3:0]       dly_i,
  output var  cpn_pkg::cpn_rx_t pd_rx_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial pd_rx_o = '0;
  task automatic send(cpn_pkg::cpn_rx_kind_t k, logic r3, logic [2:0] o, logic [11:0] v, logic [6:0] c);
    @(negedge sys_clk_i);
    pd_rx_o <= {1'b1, k, r3, o, v, c};
    @(negedge sys_clk_i);
    pd_rx_o.valid <= 1'b0;
  endtask
  // Rating zero: silent cable
  always begin
    @(posedge sys_clk_i);
    if (pd_tx_i.valid === 1'b1 && pd_tx_i.kind === cpn_pkg::TX_DISC_ID && cable_rating_i != 7'h00) begin
      repeat (dly_i) @(negedge sys_clk_i);
      send(cpn_pkg::RX_CABLE_ID, 1'b1, 3'h0, 12'h000, cable_rating_i);
    end
  end
endmodule
`default_nettype wire

/* File: tb/cpn_core_tb.sv */
// Negotiation core bench
`default_nettype none
module cpn_core_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned PDW = 200, HRS = 50, DEG = 20, DIS = 100, VCN = 30, SWL = 40;
  localparam logic [1:0]  L0 = cpn_pkg::LINE_0V0, L6 = cpn_pkg::LINE_0V6, L3 = cpn_pkg::LINE_3V3;
  logic               sys_clk_i = 1'b0, rst_b_i = 1'b0, att = 1'b0, vb5 = 1'b0, vbt = 1'b0;
  logic               dth = 1'b0, cen = 1'b0, swdet = 1'b0, sw_run = 1'b1;
  logic [1:0]         dp = 2'h0, dm = 2'h0, ccs, vcn;
  cpn_pkg::cpn_meas_t meas = '0;
  cpn_pkg::cpn_rx_t   rx;
  cpn_pkg::cpn_tx_t   tx, seen;
  cpn_pkg::cpn_stat_t stat;
  logic               bsw, opto, dfast, dslow, cont;
  logic [11:0]        vset;
  logic [6:0]         cset;
  logic [19:0]        frame;
  int unsigned        errors = 0, n_compared = 0, waited;
  always #25 sys_clk_i = ~sys_clk_i;
  always @(negedge sys_clk_i) if (sw_run) swdet <= ~swdet;
  cpn_core #(.PD_WAIT_CYC(PDW), .HRST_CYC(HRS), .DEGL_CYC(DEG), .DISCH_CYC(DIS), .VCONN_CYC(VCN),
    .SWLOSS_CYC(SWL), .CBL_WAIT_CYC(20), .CAPS_CYC(25), .OPTO_BIT_CYC(4)) u_cpn_core (
    .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .attach_i(att), .rd_on_cc2_i(1'b1), .vbus_at_5v_i(vb5),
    .vbus_at_target_i(vbt), .disch_thresh_i(dth), .cable_read_en_i(cen), .switching_detect_input_i(swdet),
    .dp_level_i(dp), .dm_level_i(dm), .pd_rx_i(rx), .meas_i(meas), .pd_tx_o(tx), .stat_o(stat),
    .bus_switch_o(bsw), .cc_source_o(ccs), .vconn_o(vcn), .opto_drive_output_o(opto),
    .disch_fast_o(dfast), .disch_slow_o(dslow), .volt_set_o(vset), .curr_set_o(cset), .cont_mode_o(cont));
  cpn_sink_model u_cpn_sink_model (.sys_clk_i(sys_clk_i), .pd_tx_i(tx), .cable_rating_i(cpn_pkg::CUR_3A),
    .dly_i(4'h3), .pd_rx_o(rx));
  task automatic check(string nm, logic [31:0] exp, logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic cyc(int unsigned n);
    repeat (n) @(negedge sys_clk_i);
  endtask
  task automatic wait_tx(cpn_pkg::cpn_tx_kind_t k, int unsigned lim);
    waited = 0;
    // Reply stands one cycle and may already be up on entry
    while (!(tx.valid === 1'b1 && tx.kind === k) && waited < lim) begin
      cyc(1);
      waited++;
    end
    seen = tx;
    check("tx", {1'b1, k}, {tx.valid, tx.kind});
  endtask
  task automatic req(logic r3, logic [2:0] o, logic [11:0] v, logic [6:0] c, cpn_pkg::cpn_tx_kind_t k);
    u_cpn_sink_model.send(cpn_pkg::RX_REQUEST, r3, o, v, c);
    wait_tx(k, 3);
    cyc(1);
  endtask
  task automatic lines(logic [1:0] p, logic [1:0] m);
    dp = p;
    dm = m;
    cyc(DEG + 8);
  endtask
  task automatic summarize();
    $display("compared %0d mismatched %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic t_pd();
    cen = 1'b1;
    att = 1'b1;
    vb5 = 1'b1;
    cyc(3);
    check("cc source", 2'h2, ccs);
    wait_tx(cpn_pkg::TX_DISC_ID, 60);
    check("disc delay", 1, waited >= VCN - 4 && waited <= VCN + 2);
    check("vconn on", 2'h1, vcn);
    wait_tx(cpn_pkg::TX_SRC_CAPS, 40);
    check("vconn off", 2'h0, vcn);
    check("pdo count", 3'h7, seen.num_pdo);
    check("cap 3A", 1'b1, seen.cap_3a);
    req(1'b1, 3'h2, cpn_pkg::V9_CODE, cpn_pkg::CUR_3A, cpn_pkg::TX_ACCEPT);
    check("volt", cpn_pkg::V9_CODE, vset);
    check("pd mode", 1'b1, stat.pd_mode);
    waited = 0;
    while (opto !== 1'b1 && waited < 20) begin
      cyc(1);
      waited++;
    end
    cyc(1);
    // Mid-bit samples, MSB first
    for (int i = 0; i < 20; i++) begin
      frame = {frame[18:0], opto};
      cyc(4);
    end
    check("opto frame", {1'b1, cpn_pkg::V9_CODE, cpn_pkg::CUR_3A}, frame);
    vbt = 1'b1;
    wait_tx(cpn_pkg::TX_PS_RDY, 20);
    req(1'b1, 3'h2, cpn_pkg::V9_CODE, cpn_pkg::CUR_3A + 7'h01, cpn_pkg::TX_REJECT);
    req(1'b1, 3'h0, cpn_pkg::V9_CODE, cpn_pkg::CUR_3A, cpn_pkg::TX_REJECT);
    check("volt kept", cpn_pkg::V9_CODE, vset);
    req(1'b0, 3'h3, cpn_pkg::V12_CODE, 7'h28, cpn_pkg::TX_ACCEPT);
    cyc(2);
    check("rev2", 1'b0, stat.rev3);
    meas <= {1'b1, 12'h123, 8'h45, 8'h67};
    cyc(1);
    meas.valid <= 1'b0;
    u_cpn_sink_model.send(cpn_pkg::RX_PPS_STAT, 1'b1, 3'h0, 12'h000, 7'h00);
    wait_tx(cpn_pkg::TX_PPS_STAT, 3);
    check("pps status", {12'h123, 8'h45, 8'h67}, seen.payload);
    u_cpn_sink_model.send(cpn_pkg::RX_STATUS, 1'b1, 3'h0, 12'h000, 7'h00);
    wait_tx(cpn_pkg::TX_STATUS, 3);
    sw_run = 1'b0;
    cyc(SWL - 6);
    check("switch held", 1'b1, bsw);
    cyc(14);
    check("switch lost", {1'b0, 2'h0}, {bsw, ccs});
    att = 1'b0;
    vb5 = 1'b0;
    vbt = 1'b0;
    sw_run = 1'b1;
    cyc(4);
    check("detach", {cpn_pkg::V5_CODE, cpn_pkg::CUR_DEF, 1'b0}, {vset, cset, stat.pd_mode});
    $display("t_pd done");
  endtask
  task automatic t_legacy();
    cen = 1'b0;
    att = 1'b1;
    vb5 = 1'b1;
    wait_tx(cpn_pkg::TX_SRC_CAPS, 40);
    check("no vconn", 2'h0, vcn);
    lines(L6, L6);
    lines(L6, L0);
    check("legacy", 1'b1, stat.legacy_mode);
    wait_tx(cpn_pkg::TX_SRC_CAPS, 30);
    dp = L3;
    dm = L6;
    cyc(DEG - 4);
    check("deglitch", cpn_pkg::V5_CODE, vset);
    cyc(12);
    check("9V", cpn_pkg::V9_CODE, vset);
    lines(L3, L3);
    check("unchanged", cpn_pkg::V9_CODE, vset);
    lines(L6, L3);
    check("continuous", 1'b1, cont);
    lines(L6, L6);
    check("12V", cpn_pkg::V12_CODE, vset);
    lines(L6, L0);
    check("5V fast", {cpn_pkg::V5_CODE, 1'b1}, {vset, dfast});
    dth = 1'b1;
    cyc(3);
    check("slow", 2'h1, {dfast, dslow});
    cyc(DIS);
    check("slow end", 1'b0, dslow);
    dth = 1'b0;
    lines(L3, L6);
    lines(L0, L0);
    check("drop", {cpn_pkg::V5_CODE, 1'b1}, {vset, dfast});
    cyc(DIS);
    check("drop end", 2'h0, {dfast, dslow});
    cyc(PDW);
    check("caps stop", 2'h1, {stat.caps_on, stat.legacy_mode});
    cen = 1'b1;
    u_cpn_sink_model.send(cpn_pkg::RX_HARD_RST, 1'b1, 3'h0, 12'h000, 7'h00);
    cyc(HRS - 6);
    check("off", 1'b0, bsw);
    cyc(12);
    check("reclose", {1'b1, cpn_pkg::V5_CODE, cpn_pkg::CUR_DEF}, {bsw, vset, cset});
    wait_tx(cpn_pkg::TX_DISC_ID, 60);
    att = 1'b0;
    cyc(4);
    $display("t_legacy done");
  endtask
  initial begin
    cyc(2);
    rst_b_i = 1'b1;
    cyc(4);
    t_pd();
    t_legacy();
    summarize();
  end
  initial begin
    #(20000 * 50);
    errors++;
    summarize();
  end
endmodule
`default_nettype wire
